// File: afr_pkg.sv
// Package for the host controller of a 64x9 strobe-handshake FIFO device.
// Assumes a single 10 MHz system clock; device pins are asynchronous to it.
package afr_pkg;
  localparam int          WORD_W        = 9;
  localparam int          DEV_DEPTH     = 64;
  localparam int          HALF_LEVEL    = 32;
  localparam int          BUF_DEPTH     = 4;
  localparam int          CLK_PERIOD_NS = 100;
  // Least strobe high and low times, in ns, and their counts in cycles
  localparam int          STROBE_MIN_NS = 30;
  localparam int          STROBE_CYC    = (STROBE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          CLEAR_MIN_NS  = 30;
  localparam int          CLEAR_CYC     = (CLEAR_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0]  CNT_ONE       = 4'h1;
  localparam logic [8:0]  WORD_RESET    = 9'h000;

  typedef struct packed {
    logic input_ready;
    logic output_ready;
    logic occupancy_flag;
    logic upper_half;
  } afr_flags_type;

  typedef enum logic [1:0] {AFR_EMPTY, AFR_PART, AFR_UPPER, AFR_FULL} afr_level_type;

  typedef enum {AFR_CLEAR, AFR_IDLE, AFR_HIGH, AFR_LOW} afr_strobe_type;
endpackage

// File: afr_fifo.sv
// Small valid/ready FIFO holding words read from the device.
// Assumes one clock and an active-high asynchronous reset.
`timescale 1ns/1ps
module afr_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 4
) (
  input  wire logic             clk_sys,
  input  wire logic             sys_rst,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  wire              push = in_valid && in_ready;
  wire              pop  = out_valid && out_ready;

  assign in_ready  = count != (AW+1)'(DEPTH);
  assign out_valid = count != '0;
  assign out_data  = mem[rd_ptr];

  always_ff @(posedge clk_sys) begin
    if (push) mem[wr_ptr] <= in_data;
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      if (pop)  rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // afr_fifo

// File: afr_host.sv
// Host controller that writes and unloads a 64x9 strobe-handshake FIFO device.
// Assumes the device pins are asynchronous; all flag inputs are synchronised here.
`timescale 1ns/1ps
module afr_host
  import afr_pkg::*;
#(
  parameter int LANES = 1
) (
  input  wire logic                          clk_sys,
  input  wire logic                          sys_rst,
  input  wire logic [afr_pkg::WORD_W-1:0]    src_data,
  input  wire logic                          src_valid,
  output logic                               src_ready,
  output logic      [afr_pkg::WORD_W-1:0]    snk_data,
  output logic                               snk_valid,
  input  wire logic                          snk_ready,
  input  wire logic                          clear_req,
  output logic                               clear_n,
  output logic                               write_strobe,
  output logic      [afr_pkg::WORD_W-1:0]    write_word,
  output logic                               read_strobe,
  output logic                               out_enable_n,
  input  wire logic [afr_pkg::WORD_W-1:0]    read_word,
  input  wire logic [LANES-1:0]              dev_input_ready,
  input  wire logic [LANES-1:0]              dev_output_ready,
  input  wire logic [LANES-1:0]              dev_occupancy_flag,
  input  wire logic [LANES-1:0]              dev_upper_half,
  output afr_pkg::afr_level_type             level
);
  import afr_pkg::*;

  logic [4*LANES-1:0] pin_meta;
  logic [4*LANES-1:0] pin_sync;
  logic [8:0]       word_meta;
  logic [8:0]       word_sync;
  afr_strobe_type   wr_state;
  afr_strobe_type   rd_state;
  logic [3:0]       wr_cnt;
  logic [3:0]       rd_cnt;
  logic [3:0]       clr_cnt;
  logic             cap_valid;
  logic             cap_ready;
  logic [8:0]       cap_data;

  function automatic afr_level_type decode_level(input logic occ, input logic upper);
    if (!occ) decode_level = upper ? AFR_FULL : AFR_EMPTY;
    else      decode_level = upper ? AFR_UPPER : AFR_PART;
  endfunction

  // Each lane passes its own two flops; only settled flags are combined
  wire [4*LANES-1:0] pin_raw = {dev_input_ready, dev_output_ready,
                                dev_occupancy_flag, dev_upper_half};
  wire afr_flags_type flags = '{&pin_sync[4*LANES-1:3*LANES], &pin_sync[3*LANES-1:2*LANES],
                                &pin_sync[2*LANES-1:LANES], &pin_sync[LANES-1:0]};

  // Two-stage synchronisers; the first stage is read by the second only
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      pin_meta  <= '0;
      pin_sync  <= '0;
      word_meta <= WORD_RESET;
      word_sync <= WORD_RESET;
    end else begin
      pin_meta  <= pin_raw;
      pin_sync  <= pin_meta;
      word_meta <= read_word;
      word_sync <= word_meta;
    end
  end

  wire wr_done   = (wr_cnt >= 4'(STROBE_CYC));
  wire rd_done   = (rd_cnt >= 4'(STROBE_CYC));
  wire clr_done  = (clr_cnt >= 4'(CLEAR_CYC));
  // Write only when the device shows room; full device would ignore it anyway
  // A pending clear blocks a new strobe, so no strobe is cut to one cycle
  wire wr_start  = src_valid && flags.input_ready && !write_strobe && !clear_req;
  // Read only with a word ready and room downstream; an empty read still held when a word lands swallows it
  wire rd_start  = flags.output_ready && cap_ready && !read_strobe && !clear_req;
  wire rd_finish = (rd_state == AFR_HIGH) && rd_done;

  // Shared control: one clear, write and read strobe drives every lane
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      clear_n <= 1'b0;
      clr_cnt <= '0;
    end else if (clear_req) begin
      clear_n <= 1'b0;
      clr_cnt <= '0;
    end else if (!clr_done) begin
      clr_cnt <= clr_cnt + CNT_ONE;
    end else begin
      clear_n <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      wr_state     <= AFR_CLEAR;
      write_strobe <= 1'b0;
      write_word   <= WORD_RESET;
      wr_cnt       <= '0;
      src_ready    <= 1'b0;
    end else begin
      src_ready <= 1'b0;
      case (wr_state)
        AFR_CLEAR: if (clear_n && clr_done) wr_state <= AFR_IDLE;
        AFR_IDLE: begin
          if (wr_start) begin
            write_strobe <= 1'b1;
            write_word   <= src_data;
            src_ready    <= 1'b1;
            wr_cnt       <= '0;
            wr_state     <= AFR_HIGH;
          end
        end
        AFR_HIGH: begin
          wr_cnt <= wr_cnt + CNT_ONE;
          if (wr_done) begin
            write_strobe <= 1'b0;
            wr_cnt       <= '0;
            wr_state     <= AFR_LOW;
          end
        end
        AFR_LOW: begin
          // Hold low long enough for the synchronised input-ready to settle
          wr_cnt <= wr_cnt + CNT_ONE;
          if (wr_cnt >= 4'(STROBE_CYC + 2)) wr_state <= AFR_IDLE;
        end
        default: wr_state <= AFR_CLEAR;
      endcase
      if (!clear_n) begin
        write_strobe <= 1'b0;
        wr_state     <= AFR_CLEAR;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      rd_state    <= AFR_CLEAR;
      read_strobe <= 1'b0;
      rd_cnt      <= '0;
      cap_valid   <= 1'b0;
      cap_data    <= WORD_RESET;
    end else begin
      cap_valid <= 1'b0;
      case (rd_state)
        AFR_CLEAR: if (clear_n && clr_done) rd_state <= AFR_IDLE;
        AFR_IDLE: begin
          if (rd_start) begin
            // Word with output ready high is the oldest; take it before the strobe
            cap_data    <= word_sync;
            cap_valid   <= 1'b1;
            read_strobe <= 1'b1;
            rd_cnt      <= '0;
            rd_state    <= AFR_HIGH;
          end
        end
        AFR_HIGH: begin
          rd_cnt <= rd_cnt + CNT_ONE;
          if (rd_finish) begin
            read_strobe <= 1'b0;
            rd_cnt      <= '0;
            rd_state    <= AFR_LOW;
          end
        end
        AFR_LOW: begin
          // Next word and output ready follow the fall; wait out the synchroniser
          rd_cnt <= rd_cnt + CNT_ONE;
          if (rd_cnt >= 4'(STROBE_CYC + 2)) rd_state <= AFR_IDLE;
        end
        default: rd_state <= AFR_CLEAR;
      endcase
      if (!clear_n) begin
        read_strobe <= 1'b0;
        rd_state    <= AFR_CLEAR;
      end
    end
  end

  // Fill level from the two composite flags, which covers full, half and empty
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      level        <= AFR_EMPTY;
      out_enable_n <= 1'b1;
    end else begin
      level        <= decode_level(flags.occupancy_flag, flags.upper_half);
      out_enable_n <= 1'b0;
    end
  end

  afr_fifo #(
    .WIDTH (WORD_W),
    .DEPTH (BUF_DEPTH)
  ) u_buf (
    .clk_sys   (clk_sys),
    .sys_rst   (sys_rst),
    .in_data   (cap_data),
    .in_valid  (cap_valid),
    .in_ready  (cap_ready),
    .out_data  (snk_data),
    .out_valid (snk_valid),
    .out_ready (snk_ready)
  );

  // Checks on the strobes that this controller drives and on the fill level it decodes
  a_read_width: assert property (@(posedge clk_sys) disable iff (sys_rst)
    $rose(read_strobe) |-> read_strobe [*2])
    else $error("read strobe too short");
  a_write_width: assert property (@(posedge clk_sys) disable iff (sys_rst)
    $rose(write_strobe) |-> write_strobe [*2])
    else $error("write strobe too short");
  a_read_ends: assert property (@(posedge clk_sys) disable iff (sys_rst)
    $rose(read_strobe) |-> ##[1:8] !read_strobe)
    else $error("read strobe held");
  a_write_ends: assert property (@(posedge clk_sys) disable iff (sys_rst)
    $rose(write_strobe) |-> ##[1:8] !write_strobe)
    else $error("write strobe held");
  a_no_full_write: assert property (@(posedge clk_sys) disable iff (sys_rst)
    $rose(write_strobe) |-> $past(flags.input_ready))
    else $error("write while not ready");
  a_no_empty_read: assert property (@(posedge clk_sys) disable iff (sys_rst)
    $rose(read_strobe) |-> $past(flags.output_ready) && cap_valid)
    else $error("read while empty");
  a_clear_quiet: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !clear_n |=> !write_strobe && !read_strobe)
    else $error("strobe during clear");
  a_level_map: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (!flags.occupancy_flag && flags.upper_half) |=> level == AFR_FULL)
    else $error("level not full");
  c_read: cover property (@(posedge clk_sys) $rose(read_strobe));
  c_write: cover property (@(posedge clk_sys) $rose(write_strobe));
  c_full: cover property (@(posedge clk_sys) level == AFR_FULL);
  c_both: cover property (@(posedge clk_sys) read_strobe && write_strobe);
endmodule // afr_host

// File: afr_dev_model.sv
// Behavioural 64x9 strobe-handshake FIFO device for the host's far side.
// Assumes strobes and clear come from the host; flags settle well inside its sync window.
`timescale 1ns/1ps
module afr_dev_model
  import afr_pkg::*;
#(
  parameter int DLY_NS = 20
) (
  input  wire logic                       clear_n,
  input  wire logic                       write_strobe,
  input  wire logic [afr_pkg::WORD_W-1:0] write_word,
  input  wire logic                       read_strobe,
  input  wire logic                       out_enable_n,
  input  wire logic                       slow,
  output logic      [afr_pkg::WORD_W-1:0] read_word,
  output logic                            input_ready,
  output logic                            output_ready,
  output logic                            occupancy_flag,
  output logic                            upper_half
);
  logic [WORD_W-1:0] mem [DEV_DEPTH];
  logic [WORD_W-1:0] word;
  logic [WORD_W-1:0] wlat;
  int                count;
  int                wp;
  int                rp;
  bit                rd_busy;
  wire               full = count == DEV_DEPTH;
  // Released outputs show the inverse so a stale word never passes
  assign read_word = out_enable_n ? ~word : word;
  assign occupancy_flag = count != 0 && !full;
  assign upper_half = full || (count != 0 && count - int'(rd_busy) >= HALF_LEVEL);
  // Strobes are modelled edge-wise, not sampled
  // Level-sensitive, so a clear that is already low at start is not missed
  always begin
    wait (clear_n === 1'b0);
    count = 0;
    wp = 0;
    rp = 0;
    rd_busy = 0;
    word = '0;
    input_ready = 1;
    output_ready = 0;
    wait (clear_n !== 1'b0);
  end
  always @(posedge write_strobe) if (clear_n) begin
    input_ready = 0;
  end
  always @(negedge write_strobe) if (clear_n) begin
    wlat = write_word;
    #(slow ? 150 : DLY_NS);
    if (!full) begin
      mem[wp] = wlat;
      wp = (wp + 1) % DEV_DEPTH;
      count++;
      if (count == 1) begin
        word = mem[rp];
        output_ready = 1;
        // A held read swallows the word 30 ns later
        if (read_strobe) begin
          #30;
          output_ready = 0;
          rp = (rp + 1) % DEV_DEPTH;
          count--;
        end
      end
    end
    input_ready = !full;
  end
  always @(posedge read_strobe) if (clear_n) begin
    output_ready = 0;
    rd_busy = count != 0;
  end
  always @(negedge read_strobe) if (clear_n && rd_busy) begin
    #(slow ? 150 : DLY_NS);
    rd_busy = 0;
    rp = (rp + 1) % DEV_DEPTH;
    count--;
    if (count != 0) begin
      word = mem[rp];
      output_ready = 1;
    end
    input_ready = 1;
  end
endmodule // afr_dev_model

// File: tb.sv
// Testbench: host against two side-by-side device models, with a queue model.
// Assumes afr_pkg, afr_fifo, afr_host and afr_dev_model are compiled first.
`timescale 1ns/1ps
module tb;
  import afr_pkg::*;
  logic clk_sys = 0, sys_rst = 1, src_valid = 0, snk_ready = 0, clear_req = 0, slow = 0;
  logic [WORD_W-1:0] src_data = '0, snk_data, write_word, read_word;
  logic src_ready, snk_valid, clear_n, write_strobe, read_strobe, out_enable_n;
  logic [1:0] dev_input_ready, dev_output_ready, dev_occupancy_flag, dev_upper_half;
  afr_level_type level;
  int err_total = 0, cmp_count = 0, taken = 0, feed = 0, sink_on = 0, i;
  logic [WORD_W-1:0] exp_q[$];
  always #50 clk_sys = ~clk_sys;
  afr_host #(.LANES(2)) dut (.clk_sys, .sys_rst, .src_data, .src_valid, .src_ready,
    .snk_data, .snk_valid, .snk_ready, .clear_req, .clear_n, .write_strobe, .write_word,
    .read_strobe, .out_enable_n, .read_word, .dev_input_ready, .dev_output_ready,
    .dev_occupancy_flag, .dev_upper_half, .level);
  // Both lanes share every control line; the second may answer slowly
  afr_dev_model dev0 (.clear_n, .write_strobe, .write_word, .read_strobe, .out_enable_n,
    .slow(1'b0), .read_word, .input_ready(dev_input_ready[0]),
    .output_ready(dev_output_ready[0]), .occupancy_flag(dev_occupancy_flag[0]),
    .upper_half(dev_upper_half[0]));
  afr_dev_model dev1 (.clear_n, .write_strobe, .write_word, .read_strobe, .out_enable_n,
    .slow, .read_word(), .input_ready(dev_input_ready[1]),
    .output_ready(dev_output_ready[1]), .occupancy_flag(dev_occupancy_flag[1]),
    .upper_half(dev_upper_half[1]));
  task automatic fail(string m);
    err_total++;
    $display("mismatch at %0t: %s", $time, m);
  endtask
  task automatic chk_word(logic [WORD_W-1:0] g, logic [WORD_W-1:0] e);
    cmp_count++;
    if (g !== e) fail("read word differs");
  endtask
  task automatic chk_level(afr_level_type e);
    cmp_count++;
    if (level !== e) fail("fill level differs");
  endtask
  task automatic chk_bit(logic g, logic e, string m);
    cmp_count++;
    if (g !== e) fail(m);
  endtask
  task automatic chk_int(int g, int e, string m);
    cmp_count++;
    if (g != e) fail(m);
  endtask
  task automatic test_done;
    $display("errors %0d comparisons %0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic wait_taken(int n);
    for (i = 0; i < 3000 && taken < n; i++) @(posedge clk_sys);
    if (taken < n) begin
      fail("write stalled");
      test_done;
    end
  endtask
  task automatic wait_drain;
    for (i = 0; i < 20000 && (exp_q.size() != 0 || src_valid); i++) @(posedge clk_sys);
    if (exp_q.size() != 0 || src_valid) begin
      fail("drain stalled");
      test_done;
    end
  endtask
  // Source holds each word until taken; sink stalls at random
  always @(posedge clk_sys) begin
    if (src_ready === 1'b1) begin
      exp_q.push_back(src_data);
      taken++;
      src_data <= WORD_W'($urandom);
      src_valid <= 1'b0;
    end else if (!src_valid) src_valid <= feed != 0 && $urandom_range(3) != 0;
    if (snk_valid === 1'b1 && snk_ready) begin
      if (exp_q.size() == 0) fail("unexpected word");
      else chk_word(snk_data, exp_q.pop_front());
    end
    snk_ready <= sink_on != 0 && $urandom_range(3) != 0;
    slow <= sink_on != 0 && $urandom_range(1) != 0;
  end
  initial begin
    void'($urandom(98510));
    repeat (4) @(posedge clk_sys);
    sys_rst <= 0;
    repeat (4) @(posedge clk_sys);
    feed = 1;
    wait_taken(10);
    repeat (30) @(posedge clk_sys);
    chk_level(AFR_PART);
    wait_taken(45);
    repeat (30) @(posedge clk_sys);
    chk_level(AFR_UPPER);
    wait_taken(68);
    repeat (100) @(posedge clk_sys);
    chk_level(AFR_FULL);
    chk_int(taken, DEV_DEPTH + BUF_DEPTH, "write taken past full");
    feed = 0;
    sink_on = 1;
    wait_drain;
    repeat (30) @(posedge clk_sys);
    chk_level(AFR_EMPTY);
    feed = 1;
    repeat (3000) @(posedge clk_sys);
    feed = 0;
    wait_drain;
    repeat (30) @(posedge clk_sys);
    chk_level(AFR_EMPTY);
    // Park words in the device with the sink stopped, then clear them away
    sink_on = 0;
    feed = 1;
    wait_taken(taken + 10);
    feed = 0;
    repeat (50) @(posedge clk_sys);
    chk_level(AFR_PART);
    clear_req <= 1'b1;
    @(posedge clk_sys);
    clear_req <= 1'b0;
    repeat (30) @(posedge clk_sys);
    chk_level(AFR_EMPTY);
    chk_bit(clear_n, 1'b1, "clear not released");
    // Only the words already in the host buffer survive the clear
    while (exp_q.size() > BUF_DEPTH) exp_q.pop_back();
    sink_on = 1;
    feed = 1;
    wait_taken(taken + 6);
    feed = 0;
    wait_drain;
    test_done;
  end
endmodule // tb
